// ---- hdl/drsr_top.sv ----
// drsr_top.sv: two-lane recirculating dynamic shift register
// assumes: phase strobes are synchronous one-cycle enables; both set is flagged and ignored
`timescale 1ns/100ps
`include "drsr_cfg.svh"

module drsr_top #(
    parameter drsr_pkg::drsr_variant_t VARIANT = drsr_pkg::DRSR_DUAL,
    parameter int LANE_LEN = `DRSR_DUAL_LEN
) (
    input wire logic clk,
    input wire logic nrst,
    input drsr_pkg::drsr_phase_t phase,
    input wire logic recirc_or_load_select,
    input drsr_pkg::drsr_lane_in_t lane_a,
    input drsr_pkg::drsr_lane_in_t lane_b,
    output logic out_a,
    output logic out_b,
    output logic phase_clash
);
    import drsr_pkg::*;

    localparam int LEN = (VARIANT == DRSR_SINGLE) ? `DRSR_SINGLE_LEN : LANE_LEN;
    localparam int HALF = LEN / 2;

    initial begin
        if (LEN < 4 || (LEN % 2) != 0) begin
            $error("drsr_top: length must be even and at least 4");
        end
    end

    logic en1;
    logic en2;
    logic fb_a;
    logic fb_b;
    logic in_a;
    logic in_b;
    logic out_a_q;
    logic out_b_q;
    logic clash_q;

    // phase one and phase two as enables on one system clock
    assign en1 = phase.ph1 & ~phase.ph2;
    assign en2 = phase.ph2 & ~phase.ph1;

    // =====================================
    // entered bit selection
    function automatic logic pick_bit(input drsr_lane_in_t li, input logic recirc,
                                      input logic fb);
        logic src;
        src = (VARIANT == DRSR_DUAL_IN && li.input_source_choice) ?
              li.data_in_two : li.data_in_one;
        return recirc ? fb : src;
    endfunction

    assign in_a = pick_bit(lane_a, recirc_or_load_select, fb_a);
    assign in_b = pick_bit(lane_b, recirc_or_load_select, fb_b);

    // =====================================
    // lanes; two interleaved halves each
    logic [1:0] ha_out;
    logic [1:0] hb_out;

    // half 0 captures on phase one, half 1 on phase two
    drsr_half #(.LEN(HALF)) u_a0 (
        .clk(clk), .nrst(nrst), .cap_en(en1), .xfer_en(en2),
        .bit_in(in_a), .bit_out(ha_out[0])
    );
    drsr_half #(.LEN(HALF)) u_a1 (
        .clk(clk), .nrst(nrst), .cap_en(en2), .xfer_en(en1),
        .bit_in(in_a), .bit_out(ha_out[1])
    );

    generate
        if (VARIANT != DRSR_SINGLE) begin : g_lane_b
            drsr_half #(.LEN(HALF)) u_b0 (
                .clk(clk), .nrst(nrst), .cap_en(en1), .xfer_en(en2),
                .bit_in(in_b), .bit_out(hb_out[0])
            );
            drsr_half #(.LEN(HALF)) u_b1 (
                .clk(clk), .nrst(nrst), .cap_en(en2), .xfer_en(en1),
                .bit_in(in_b), .bit_out(hb_out[1])
            );
        end else begin : g_no_b
            assign hb_out = 2'h0;
        end
    endgenerate

    // feedback is the bit currently presented at the output
    assign fb_a = out_a_q;
    assign fb_b = out_b_q;

    // =====================================
    // output: on each phase, present the half that entered on it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else if (en1) begin
            out_a_q <= ha_out[0];
            out_b_q <= hb_out[0];
        end else if (en2) begin
            out_a_q <= ha_out[1];
            out_b_q <= hb_out[1];
        end
    end

    // =====================================
    // flag illegal overlap; both phases ignored then (data held)
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clash_q <= 1'b0;
        end else begin
            clash_q <= phase.ph1 & phase.ph2;
        end
    end

    assign out_a = out_a_q;
    assign out_b = out_b_q;
    assign phase_clash = clash_q;
endmodule // drsr_top

// ---- hdl/drsr_cfg.svh ----
// drsr_cfg.svh: sizes and encodings for the recirculating shift register
// assumes: included by the package and design files by bare name
`ifndef DRSR_CFG_SVH
`define DRSR_CFG_SVH

// =====================================
// register lengths
`define DRSR_DUAL_LEN 1024
`define DRSR_SINGLE_LEN 2048

// =====================================
// variant codes
`define DRSR_VAR_DUAL 2'h0
`define DRSR_VAR_DUAL_IN 2'h1
`define DRSR_VAR_SINGLE 2'h2

// =====================================
// phase encoding of the phase strobe bundle
`define DRSR_PH_NONE 2'h0
`define DRSR_PH_ONE 2'h1
`define DRSR_PH_TWO 2'h2
`define DRSR_PH_BOTH 2'h3

`endif

// ---- hdl/drsr_pkg.sv ----
// drsr_pkg.sv: types shared by the shift register files
// assumes: drsr_cfg.svh on the include path
`include "drsr_cfg.svh"

package drsr_pkg;
    // =====================================
    // variant select
    typedef enum logic [1:0] {
        DRSR_DUAL = 2'b00,
        DRSR_DUAL_IN = 2'b01,
        DRSR_SINGLE = 2'b10
    } drsr_variant_t;

    // =====================================
    // per-register input bundle
    typedef struct packed {
        logic data_in_one;
        logic data_in_two;
        logic input_source_choice;
    } drsr_lane_in_t;

    // =====================================
    // two-phase strobes: [0] phase one, [1] phase two
    typedef struct packed {
        logic ph2;
        logic ph1;
    } drsr_phase_t;
endpackage

// ---- hdl/drsr_half.sv ----
// drsr_half.sv: one half-register, master/slave cells in a delay line
// assumes: phase strobes are one-cycle enables from the parent
`timescale 1ns/100ps
`include "drsr_cfg.svh"

module drsr_half #(
    parameter int LEN = 512
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cap_en,
    input wire logic xfer_en,
    input wire logic bit_in,
    output logic bit_out
);
    import drsr_pkg::*;

    // no reset on slave_q storage, like the charge nodes it models; master_q is reset
    logic [LEN-1:0] slave_q;
    logic master_q;

    initial begin
        if (LEN < 2) begin
            $error("drsr_half: LEN below 2");
        end
    end

    // =====================================
    // capture into first stage on own phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_q <= 1'b0;
        end else if (cap_en) begin
            master_q <= bit_in;
        end
    end

    // =====================================
    // move to second stage on the other phase
    always_ff @(posedge clk) begin
        if (xfer_en) begin
            slave_q <= {slave_q[LEN-2:0], master_q};
        end
    end

    assign bit_out = slave_q[LEN-1];
endmodule // drsr_half

// ---- tb/drsr_chk.sv ----
// drsr_chk.sv: port checks on the shift register top
// assumes: bound to drsr_top, one clock domain
`timescale 1ns/100ps
module drsr_chk import drsr_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input drsr_phase_t phase,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic phase_clash
);
    // =====================================
    // strobe and output timing
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    clash_flag_a: assert property (phase == 2'h3 |=> phase_clash)
        else $error("clash not flagged");
    clash_clear_a: assert property (phase != 2'h3 |=> !phase_clash)
        else $error("stray flag");
    clash_hold_a: assert property (phase == 2'h3 |=> $stable({out_a, out_b}))
        else $error("shift on clash");
    idle_hold_a: assert property (phase == 2'h0 |=> $stable({out_a, out_b}))
        else $error("shift when idle");
    a_moves_a: assert property ($changed(out_a) |-> $past(phase) inside {2'h1, 2'h2})
        else $error("lane a moved");
    b_moves_a: assert property ($changed(out_b) |-> $past(phase) inside {2'h1, 2'h2})
        else $error("lane b moved");
    flag_cause_a: assert property ($rose(phase_clash) |-> $past(phase) == 2'h3)
        else $error("flag cause");
    reset_zero_a: assert property (disable iff (1'b0) !nrst |-> !out_a && !out_b)
        else $error("outputs in reset");
endmodule // drsr_chk
bind drsr_top drsr_chk drsr_chk_i (.clk, .nrst, .phase, .out_a, .out_b, .phase_clash);

// ---- tb/drsr_drv.sv ----
// drsr_drv.sv: far-side driver of the two phase strobes
// assumes: bench requests stalls and clashes
`timescale 1ns/100ps
module drsr_drv import drsr_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic clash,
    output drsr_phase_t phase
);
    logic two_q;
    // =====================================
    // strobes move on the falling edge, away from sampling
    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
            two_q <= 1'b0;
        end else if (clash) begin
            phase <= 2'h3;
        end else if (stall) begin
            phase <= 2'h0;
        end else begin
            phase <= two_q ? 2'h2 : 2'h1;
            two_q <= !two_q;
        end
    end
endmodule // drsr_drv

// ---- tb/tb.sv ----
// tb.sv: self-checking bench, queue model of both lanes
// assumes: dual-input variant with short lanes
`timescale 1ns/100ps
module tb;
    import drsr_pkg::*;
    localparam int LEN = 8;
    logic clk, nrst, stall, clash, recirc, out_a, out_b, phase_clash;
    logic out_c, out_d, clash_dual;
    logic q_c[$], q_d[$];
    logic exp_c = 1'b0, exp_d = 1'b0;
    drsr_phase_t phase;
    drsr_lane_in_t lane_a, lane_b;
    int seed = 67, mismatches = 0, n_checks = 0, pulses = 0, cycles = 0;
    logic q_a[$], q_b[$];
    logic exp_a = 1'b0, exp_b = 1'b0, exp_clash = 1'b0;
    drsr_drv drsr_drv_i (.clk, .nrst, .stall, .clash, .phase);
    drsr_top #(.VARIANT(DRSR_DUAL_IN), .LANE_LEN(LEN)) drsr_top_i (.clk, .nrst, .phase,
        .recirc_or_load_select(recirc), .lane_a, .lane_b, .out_a, .out_b, .phase_clash);
    // plain dual variant on the same stimulus: select and input two must be ignored
    drsr_top #(.VARIANT(DRSR_DUAL), .LANE_LEN(LEN)) drsr_top_dual_i (.clk, .nrst, .phase,
        .recirc_or_load_select(recirc), .lane_a, .lane_b, .out_a(out_c), .out_b(out_d),
        .phase_clash(clash_dual));
    function automatic logic pick_one(logic fb, drsr_lane_in_t l);
        return recirc ? fb : l.data_in_one;
    endfunction
    function automatic logic pick(logic fb, drsr_lane_in_t l);
        return recirc ? fb : (l.input_source_choice ? l.data_in_two : l.data_in_one);
    endfunction
    task automatic chk(string name, logic exp, logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // =====================================
    // model: a pulse enters one bit and emits the bit from LEN pulses before
    always @(posedge clk) begin
        cycles++;
        if (cycles > 4000) begin
            mismatches++;
            tally_and_finish();
        end
        if (nrst) begin
            exp_clash = (phase == 2'h3);
            if (phase == 2'h1 || phase == 2'h2) begin
                q_a.push_back(pick(exp_a, lane_a));
                q_b.push_back(pick(exp_b, lane_b));
                exp_a = q_a.pop_front();
                exp_b = q_b.pop_front();
                q_c.push_back(pick_one(exp_c, lane_a));
                q_d.push_back(pick_one(exp_d, lane_b));
                exp_c = q_c.pop_front();
                exp_d = q_d.pop_front();
                pulses++;
            end
        end
    end
    // recirculation stays off until the unreset storage has filled
    always @(negedge clk) begin
        if (pulses > 2 * LEN) begin
            chk("out_a", exp_a, out_a);
            chk("out_b", exp_b, out_b);
            chk("phase_clash", exp_clash, phase_clash);
            chk("dual_out_a", exp_c, out_c);
            chk("dual_out_b", exp_d, out_d);
            chk("dual_clash", exp_clash, clash_dual);
        end
        lane_a <= 3'($random(seed));
        lane_b <= 3'($random(seed));
        recirc <= (pulses > 2 * LEN) && ($random(seed) % 4 != 0);
        stall <= ($random(seed) % 5 == 0);
        clash <= (pulses > 2 * LEN) && ($random(seed) % 23 == 0);
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        {stall, clash, recirc, lane_a, lane_b} = 9'h000;
        for (int i = 0; i < LEN; i++) begin
            q_a.push_back(1'b0);
            q_b.push_back(1'b0);
            q_c.push_back(1'b0);
            q_d.push_back(1'b0);
        end
        repeat (16) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        chk("out_a", 1'b0, out_a);
        repeat (2000) @(posedge clk);
        tally_and_finish();
    end
endmodule // tb
